//--- sbm_ctl.sv
`timescale 1ns/1ns
module sbm_ctl (
    input  wire logic        ref_clk,   // Controller clock.
    input  wire logic        rst_n,     // Async reset, low.
    input  wire logic [31:0] haddr,     // AHB address.
    input  wire logic [1:0]  htrans,    // AHB transfer type.
    input  wire logic        hwrite,    // AHB write.
    input  wire logic [2:0]  hsize,     // AHB size.
    input  wire logic [31:0] hwdata,    // AHB write data.
    input  wire logic        hsel,      // AHB select.
    input  wire logic        hready,    // AHB bus ready.
    output logic [31:0]      hrdata,    // AHB read data.
    output logic             hreadyout, // Always ready.
    output logic             hresp,     // Always OKAY.
    sbm_link_if.ctl          link       // Device link.
);
    logic [9:0]  mode_r;
    logic [7:0]  ext_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic [1:0]  gap_r;
    logic        ap_wr_r;
    logic        ap_rd_r;
    logic [7:0]  ap_addr_r;
    logic        take;
    assign take = hsel && hready && htrans[1];

    // ---------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_wr_r   <= 1'b0;
            ap_rd_r   <= 1'b0;
            ap_addr_r <= 8'h00;
        end else begin
            ap_wr_r   <= take && hwrite;
            ap_rd_r   <= take && !hwrite;
            ap_addr_r <= haddr[7:0];
        end
    end

    // Read data stands through the data phase.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                sbm_pkg::REG_MODE:   hrdata <= {22'h0, mode_r};
                sbm_pkg::REG_EXT:    hrdata <= {24'h0, ext_r};
                sbm_pkg::REG_STATUS: hrdata <= {31'h0, gap_r != 2'h0};
                sbm_pkg::REG_RDATA:  hrdata <= {16'h0, rdata_r};
                default:             hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software registers; reserved bits go out zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= sbm_pkg::MODE_RST;
            ext_r   <= sbm_pkg::EXT_RST;
            wdata_r <= 16'h0000;
        end else if (ap_wr_r) begin
            case (ap_addr_r)
                sbm_pkg::REG_MODE:  mode_r  <= {hwdata[9], 2'h0,
                                                hwdata[6:0]};
                sbm_pkg::REG_EXT:   ext_r   <= {hwdata[7:5], 2'h0,
                                                hwdata[2:0]};
                sbm_pkg::REG_WDATA: wdata_r <= hwdata[15:0];
                default:            ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Command issue; software keeps banks idle for mode loads.
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hf;
            link.cke       <= 1'b1;
            link.ba        <= 2'h0;
            link.addr      <= 13'h0000;
            link.dq_ctl    <= 16'h0000;
            link.dq_ctl_oe <= 1'b0;
            gap_r          <= 2'h0;
        end else begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                <= sbm_pkg::CMD_NOP;
            link.dq_ctl_oe <= 1'b0;
            if (gap_r != 2'h0)
                gap_r <= gap_r - 2'h1;
            if (ap_wr_r && ap_addr_r == sbm_pkg::REG_CMD
                && gap_r == 2'h0) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                    <= hwdata[sbm_pkg::CMD_OP_LSB +: 4];
                link.cke <= !hwdata[20];
                if (hwdata[sbm_pkg::CMD_OP_LSB +: 4] == sbm_pkg::CMD_LMR)
                begin
                    gap_r <= 2'(sbm_pkg::TMRD_CYC);
                    if (hwdata[21]) begin
                        link.ba   <= sbm_pkg::BANK_SEL_EXT;
                        link.addr <= {5'h0, ext_r};
                    end else begin
                        link.ba   <= sbm_pkg::BANK_SEL_BASE;
                        link.addr <= {3'h0, mode_r};
                    end
                end else begin
                    link.ba   <= hwdata[14:13];
                    link.addr <= hwdata[12:0];
                end
                link.dq_ctl    <= wdata_r;
                link.dq_ctl_oe <= hwdata[sbm_pkg::CMD_OP_LSB +: 4]
                                  == sbm_pkg::CMD_WRITE;
            end
        end
    end

    // Last device word, kept for software.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            rdata_r <= 16'h0000;
        else if (link.dq_dev_oe)
            rdata_r <= link.dq_dev;
    end
endmodule : sbm_ctl

//--- sbm_device.sv
`timescale 1ns/1ns
// How it works
// - BL2: A1-A8 pick block, A0 start
// - BL4: A2-A8 pick block, A0-A1 start
// - BL8: A3-A8 pick block, A0-A2 start
// - Full page: 512 columns, sequential only
// - Burst wraps inside its own block
// - BL1: exact column, burst type ignored
// - Sequential adds count, interleaved XORs count
// - Controller programs operating mode zero
// - Read latency one, two or three
// - Drive after r+q-1, valid at r+q
// - Controller picks latency legal for clock; the controller sends whatever latency software writes to REG_MODE, unchecked
// - Write-single bit makes writes one location
// - Bank select 10 loads extended register
// - Controller writes reserved extended bits zero
// - Extended load only when idle, wait after
// - Extended register holds until reloaded
// - Temperature sensor scales self refresh rate
// - Self refresh only selected array portion
// - Partial refresh coverage encoding
// - Output drive level encoding
// - Base mode register field layout
// - Lengths 1-8 both types, page sequential
module sbm_device #(
    parameter int TEMP_W = sbm_pkg::TEMP_BITS
) (
    input  wire logic              ref_clk,         // Device clock.
    input  wire logic              rst_n,           // Async reset, low.
    sbm_link_if.dev                link,            // Controller link.
    input  wire logic [TEMP_W-1:0] temp_level,      // On-chip sensor.
    output logic [8:0]             col_addr,        // Column accessed.
    output logic                   col_valid,       // Column cycle.
    output logic                   col_write,       // Access is write.
    output logic [15:0]            wr_data,         // Data to array.
    input  wire logic [15:0]       rd_data,         // Data from array.
    output logic [2:0]             partial_refresh_select, // Coverage.
    output logic [2:0]             output_drive_level,     // Drive.
    output logic [TEMP_W-1:0]      refresh_interval,       // Self ref.
    output logic [3:0]             refresh_bank_mask       // Kept banks.
);
    // ---------------------------------------------------------------
    // Mode storage
    // ---------------------------------------------------------------
    logic [9:0] mode_r;
    logic [7:0] ext_r;
    logic [3:0] cmd;
    logic       self_ref_r;
    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

    // Both registers hold until reloaded.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= sbm_pkg::MODE_RST;
            ext_r  <= sbm_pkg::EXT_RST;
        end else if (link.cke && cmd == sbm_pkg::CMD_LMR) begin
            if (link.ba == sbm_pkg::BANK_SEL_EXT)
                ext_r <= link.addr[7:0];
            else if (link.ba == sbm_pkg::BANK_SEL_BASE)
                mode_r <= link.addr[9:0];
        end
    end

    // Fields of the base mode register.
    logic [2:0] bl_code;
    logic       interleave;
    logic [2:0] cl_code;
    logic       write_single_bit;
    assign bl_code          = mode_r[sbm_pkg::BL_LSB +: 3];
    assign interleave       = mode_r[sbm_pkg::BT_POS];
    assign cl_code          = mode_r[sbm_pkg::CL_LSB +: 3];
    assign write_single_bit = mode_r[sbm_pkg::WB_POS];

    // Wrap block mask for a length code.
    function automatic logic [8:0] blk_mask(input logic [2:0] code);
        case (code)
            sbm_pkg::BL_2:    blk_mask = 9'h001;
            sbm_pkg::BL_4:    blk_mask = 9'h003;
            sbm_pkg::BL_8:    blk_mask = 9'h007;
            sbm_pkg::BL_PAGE: blk_mask = 9'h1ff;
            default:          blk_mask = 9'h000;
        endcase
    endfunction : blk_mask

    // Column for step n of a burst.
    function automatic logic [8:0] burst_col(input logic [8:0] start,
                                            input logic [8:0] n,
                                            input logic [8:0] m,
                                            input logic       il);
        logic [8:0] low;
        low = il ? ((start ^ n) & m) : ((start + n) & m);
        burst_col = (start & ~m) | low;
    endfunction : burst_col

    // ---------------------------------------------------------------
    // Burst address generator
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BURST} sbm_st_t;
    sbm_st_t    st_r;
    logic [8:0] start_r;
    logic [8:0] mask_r;
    logic       il_r;
    logic [8:0] step_r;
    logic [1:0] wait_r;
    logic       new_rd;
    logic       new_wr;
    logic [8:0] m_nxt;
    assign new_rd = link.cke && cmd == sbm_pkg::CMD_READ;
    assign new_wr = link.cke && cmd == sbm_pkg::CMD_WRITE;

    // Write-single mode shrinks a write to one column.
    always_comb begin
        m_nxt = blk_mask(bl_code);
        if (new_wr && write_single_bit)
            m_nxt = 9'h000;
    end

    // A read waits latency-1 cycles; a new read or write truncates a burst.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= ST_IDLE;
            start_r   <= 9'h000;
            mask_r    <= 9'h000;
            il_r      <= 1'b0;
            step_r    <= 9'h000;
            wait_r    <= 2'h0;
            col_write <= 1'b0;
        end else if (new_rd || new_wr) begin
            start_r   <= link.addr[8:0];
            mask_r    <= m_nxt;
            il_r      <= interleave && bl_code != sbm_pkg::BL_PAGE;
            step_r    <= 9'h000;
            col_write <= new_wr;
            wait_r    <= new_rd ? 2'(cl_code - 3'h1) : 2'h0;
            st_r      <= (new_rd && cl_code > 3'h1) ? ST_WAIT : ST_BURST;
        end else begin
            case (st_r)
                ST_IDLE: st_r <= ST_IDLE;
                ST_WAIT: begin
                    wait_r <= wait_r - 2'h1;
                    if (wait_r == 2'h1)
                        st_r <= ST_BURST;
                end
                ST_BURST: begin
                    step_r <= step_r + 9'h001;
                    if (step_r == mask_r)
                        st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Column output register, one address per cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_addr  <= 9'h000;
            col_valid <= 1'b0;
            wr_data   <= 16'h0000;
        end else begin
            col_valid <= st_r == ST_BURST && !(new_rd || new_wr);
            col_addr  <= burst_col(start_r, step_r, mask_r, il_r);
            wr_data   <= link.dq_ctl;
        end
    end

    // Read data out, registered with the column word.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.dq_dev    <= 16'h0000;
            link.dq_dev_oe <= 1'b0;
        end else begin
            link.dq_dev    <= rd_data;
            link.dq_dev_oe <= st_r == ST_BURST && !col_write
                              && !(new_rd || new_wr);
        end
    end

    // ---------------------------------------------------------------
    // Low power controls
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            self_ref_r <= 1'b0;
        else if (!link.cke && cmd == sbm_pkg::CMD_REF)
            self_ref_r <= 1'b1;
        else if (link.cke)
            self_ref_r <= 1'b0;
    end

    // Hotter die gives a shorter interval; the sensor is read live.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_interval       <= '0;
            refresh_bank_mask      <= 4'h0;
            partial_refresh_select <= 3'h0;
            output_drive_level     <= 3'h0;
        end else begin
            refresh_interval <= ~temp_level;
            partial_refresh_select <= ext_r[sbm_pkg::PRS_LSB +: 3];
            output_drive_level <= ext_r[sbm_pkg::ODL_LSB +: 3];
            if (!self_ref_r)
                refresh_bank_mask <= 4'h0;
            else
                case (ext_r[sbm_pkg::PRS_LSB +: 3])
                    3'h0:    refresh_bank_mask <= 4'hf;
                    3'h1:    refresh_bank_mask <= 4'h3;
                    default: refresh_bank_mask <= 4'h1;
                endcase
        end
    end
endmodule : sbm_device

//--- sbm_link_if.sv
`timescale 1ns/1ns
interface sbm_link_if;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [15:0] dq_ctl;   // Data driven by the controller.
    logic        dq_ctl_oe;
    logic [15:0] dq_dev;   // Data driven by the device.
    logic        dq_dev_oe;

    modport ctl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr,
                 dq_ctl, dq_ctl_oe, input dq_dev, dq_dev_oe);
    modport dev (input cs_n, ras_n, cas_n, we_n, cke, ba, addr,
                 dq_ctl, dq_ctl_oe, output dq_dev, dq_dev_oe);
endinterface : sbm_link_if

//--- sbm_link_monitor.sv
`timescale 1ns/1ns
module sbm_link_monitor (
    input  wire logic        ref_clk,   // Link clock.
    input  wire logic        rst_n,     // Async reset, low.
    input  wire logic        cs_n,      // Chip select, low.
    input  wire logic        ras_n,     // Row strobe, low.
    input  wire logic        cas_n,     // Column strobe, low.
    input  wire logic        we_n,      // Write enable, low.
    input  wire logic        cke,       // Clock enable.
    input  wire logic [1:0]  ba,        // Bank select.
    input  wire logic [12:0] addr,      // Address or opcode.
    input  wire logic [15:0] dq_ctl,    // Controller data.
    input  wire logic        dq_ctl_oe, // Controller drives data.
    input  wire logic [15:0] dq_dev,    // Device data.
    input  wire logic        dq_dev_oe  // Device drives data.
);
    // ---------------------------------------------------------------
    // Decoded commands and last mode
    // ---------------------------------------------------------------
    logic [3:0] cmd;
    logic       rd;
    logic       lmr_base;
    logic       lmr_ext;
    logic       quiet;
    logic [2:0] bl_r;
    logic [2:0] cl_r;

    // Commands come from the wire alone.
    assign cmd      = {cs_n, ras_n, cas_n, we_n};
    assign rd       = cke && cmd == sbm_pkg::CMD_READ;
    assign lmr_base = cmd == sbm_pkg::CMD_LMR && ba == sbm_pkg::BANK_SEL_BASE;
    assign lmr_ext  = cmd == sbm_pkg::CMD_LMR && ba == sbm_pkg::BANK_SEL_EXT;
    assign quiet    = cs_n || cmd == sbm_pkg::CMD_NOP;

    // Length and latency follow each base load.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bl_r <= sbm_pkg::MODE_RST[2:0];
            cl_r <= sbm_pkg::MODE_RST[6:4];
        end else if (lmr_base) begin
            bl_r <= addr[2:0];
            cl_r <= addr[6:4];
        end
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Output off one cycle, then on.
    sequence oe_first;
        !dq_dev_oe ##1 dq_dev_oe;
    endsequence

    lmr_gap_a: assert property (lmr_base || lmr_ext |=> quiet [*2])
        else $error("mode load gap");
    op_mode_a: assert property (lmr_base |-> addr[8:7] == 2'h0)
        else $error("op mode nonzero");
    ext_zero_a: assert property (lmr_ext |-> addr[12:8] == 5'h0
        && addr[4:3] == 2'h0) else $error("reserved bits");
    lat_one_a: assert property (rd && cl_r == 3'h1 |-> ##1 oe_first)
        else $error("latency one");
    lat_two_a: assert property (rd && cl_r == 3'h2 |-> ##2 oe_first)
        else $error("latency two");
    lat_three_a: assert property (rd && cl_r == 3'h3 |-> ##3 oe_first)
        else $error("latency three");
    burst_one_a: assert property ($rose(dq_dev_oe)
        && bl_r == sbm_pkg::BL_1 |=> !dq_dev_oe) else $error("length one");
    burst_four_a: assert property ($rose(dq_dev_oe)
        && bl_r == sbm_pkg::BL_4 |-> dq_dev_oe [*4] ##1 !dq_dev_oe)
        else $error("burst four");
    burst_eight_a: assert property ($rose(dq_dev_oe)
        && bl_r == sbm_pkg::BL_8 |-> dq_dev_oe [*8] ##1 !dq_dev_oe)
        else $error("burst eight");
    no_clash_a: assert property (!(dq_dev_oe && dq_ctl_oe))
        else $error("data clash");
    self_ref_a: assert property (!cke |-> !dq_dev_oe)
        else $error("self refresh drive");
endmodule : sbm_link_monitor

//--- sbm_pkg.sv
package sbm_pkg;
    // ---------------------------------------------------------------
    // Command encodings, {cs_n, ras_n, cas_n, we_n}
    // ---------------------------------------------------------------
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_LMR   = 4'h0;
    localparam logic [3:0] CMD_REF   = 4'h1;

    // ---------------------------------------------------------------
    // Base mode register fields
    // ---------------------------------------------------------------
    localparam int BL_LSB  = 0;
    localparam int BT_POS  = 3;
    localparam int CL_LSB  = 4;
    localparam int OP_LSB  = 7;
    localparam int WB_POS  = 9;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam int PAGE_COLS       = 512;

    // ---------------------------------------------------------------
    // Low power config register fields and bank select values
    // ---------------------------------------------------------------
    localparam int PRS_LSB = 0;
    localparam int ODL_LSB = 5;
    localparam logic [1:0] BANK_SEL_EXT  = 2'h2;
    localparam logic [1:0] BANK_SEL_BASE = 2'h0;

    // ---------------------------------------------------------------
    // Controller register map and resets
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_MODE   = 8'h00;
    localparam logic [7:0] REG_EXT    = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_WDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA  = 8'h14;
    localparam logic [9:0] MODE_RST   = 10'h023;
    localparam logic [7:0] EXT_RST    = 8'h00;
    localparam int CMD_OP_LSB  = 16;
    localparam int TEMP_BITS   = 8;
    localparam int TMRD_CYC    = 2;
endpackage : sbm_pkg

//--- test_sdram_burst_mode_config.sv
`timescale 1ns/1ns
module test_sdram_burst_mode_config;
    logic        ref_clk;
    logic        rst_n;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hsel;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  temp_level;
    logic [15:0] rd_data;
    logic [8:0]  col_addr;
    logic        col_valid;
    logic        col_write;
    logic [15:0] wr_data;
    logic [2:0]  partial_refresh_select;
    logic [2:0]  output_drive_level;
    logic [7:0]  refresh_interval;
    logic [3:0]  refresh_bank_mask;
    int          failures;
    int          n_tests;
    logic [2:0]  prs [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [3:0]  msk [5] = '{4'hf, 4'h3, 4'h1, 4'h1, 4'h1};

    // One slave: its ready is the bus ready.
    assign hready = hreadyout;
    sbm_link_if link_bus ();
    sbm_ctl u_sbm_ctl (.ref_clk(ref_clk), .rst_n(rst_n), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hsel(hsel), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link_bus));
    sbm_device u_sbm_device (.ref_clk(ref_clk), .rst_n(rst_n),
        .link(link_bus), .temp_level(temp_level), .col_addr(col_addr),
        .col_valid(col_valid), .col_write(col_write), .wr_data(wr_data),
        .rd_data(rd_data), .partial_refresh_select(partial_refresh_select),
        .output_drive_level(output_drive_level),
        .refresh_interval(refresh_interval),
        .refresh_bank_mask(refresh_bank_mask));
    sbm_link_monitor u_sbm_link_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
        .cs_n(link_bus.cs_n), .ras_n(link_bus.ras_n),
        .cas_n(link_bus.cas_n), .we_n(link_bus.we_n), .cke(link_bus.cke),
        .ba(link_bus.ba), .addr(link_bus.addr), .dq_ctl(link_bus.dq_ctl),
        .dq_ctl_oe(link_bus.dq_ctl_oe), .dq_dev(link_bus.dq_dev),
        .dq_dev_oe(link_bus.dq_dev_oe));

    // ---------------------------------------------------------------
    // Bus and checking tasks
    // ---------------------------------------------------------------
    // A 100 ns clock, free running.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic results;
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Bounded wait; a stuck slave ends the run.
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                failures++;
                results();
            end
            @(posedge ref_clk);
        end
    endtask : wait_rdy

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel   <= 1'b1;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check("register read", e, q);
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic send(input logic [3:0] c, input logic ext,
                        input logic ckl, input logic [1:0] b,
                        input logic [12:0] a);
        wr(sbm_pkg::REG_CMD, {10'h000, ext, ckl, c, 1'b0, b, a});
    endtask : send

    // Idle time covers the load gap.
    task automatic set_mode(input logic [9:0] m);
        wr(sbm_pkg::REG_MODE, 32'(m));
        send(sbm_pkg::CMD_LMR, 1'b0, 1'b0, sbm_pkg::BANK_SEL_BASE, 13'(m));
        idle(4);
    endtask : set_mode

    task automatic set_ext(input logic [7:0] x);
        wr(sbm_pkg::REG_EXT, 32'(x));
        send(sbm_pkg::CMD_LMR, 1'b1, 1'b0, sbm_pkg::BANK_SEL_EXT, 13'(x));
        idle(4);
    endtask : set_ext

    // One access; compare every column stepped through.
    task automatic burst(input logic [3:0] c, input int n,
                         input logic [8:0] st, input logic il);
        int         k;
        logic [8:0] m9;
        logic [8:0] lo;
        logic [8:0] e;
        k  = 0;
        m9 = 9'(n - 1);
        lo = st & m9;
        send(c, 1'b0, 1'b0, 2'h0, {4'h0, st});
        repeat (n + 8) begin
            @(negedge ref_clk);
            if (col_valid === 1'b1) begin
                e = (st & ~m9) | (il ? (lo ^ 9'(k)) : ((lo + 9'(k)) & m9));
                check("column", 32'(e), 32'(col_addr));
                check("write flag", 32'(c == sbm_pkg::CMD_WRITE),
                      32'(col_write));
                if (c == sbm_pkg::CMD_WRITE) begin
                    check("write data", 32'h5a3c, 32'(wr_data));
                end
                k++;
            end
        end
        check("column count", 32'(n), 32'(k));
        @(posedge ref_clk);
    endtask : burst

    task automatic run_read(input logic [2:0] bl, input logic bt,
                            input logic [2:0] cl, input logic [8:0] st,
                            input int n);
        set_mode({1'b0, 2'h0, cl, bt, bl});
        burst(sbm_pkg::CMD_READ, n, st, bt);
        rd_chk(sbm_pkg::REG_RDATA, {16'h0000, rd_data});
    endtask : run_read

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        failures   = 0;
        n_tests    = 0;
        rst_n      = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        hsel       = 1'b0;
        temp_level = 8'h30;
        rd_data    = 16'hc3a5;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd_chk(sbm_pkg::REG_MODE, 32'(sbm_pkg::MODE_RST));
        rd_chk(sbm_pkg::REG_EXT, 32'(sbm_pkg::EXT_RST));
        rd_chk(8'h40, 32'h0);
        wr(sbm_pkg::REG_MODE, 32'h3ff);
        rd_chk(sbm_pkg::REG_MODE, 32'h27f);
        wr(sbm_pkg::REG_EXT, 32'hff);
        rd_chk(sbm_pkg::REG_EXT, 32'he7);
        // Each length, both orders at BL4 and BL8; starts force a wrap.
        run_read(sbm_pkg::BL_1, 1'b1, 3'h1, 9'h1a5, 1);
        run_read(sbm_pkg::BL_2, 1'b0, 3'h2, 9'h0f3, 2);
        run_read(sbm_pkg::BL_4, 1'b1, 3'h3, 9'h0b5, 4);
        run_read(sbm_pkg::BL_4, 1'b0, 3'h1, 9'h1fd, 4);
        run_read(sbm_pkg::BL_8, 1'b1, 3'h2, 9'h0ed, 8);
        run_read(sbm_pkg::BL_8, 1'b0, 3'h3, 9'h1fe, 8);
        run_read(sbm_pkg::BL_PAGE, 1'b0, 3'h2, 9'h1fe, 512);
        // Writes burst, then go single; reads still burst.
        wr(sbm_pkg::REG_WDATA, 32'h00005a3c);
        set_mode({1'b0, 2'h0, 3'h2, 1'b0, sbm_pkg::BL_4});
        burst(sbm_pkg::CMD_WRITE, 4, 9'h016, 1'b0);
        set_mode({1'b1, 2'h0, 3'h2, 1'b0, sbm_pkg::BL_4});
        burst(sbm_pkg::CMD_WRITE, 1, 9'h016, 1'b0);
        burst(sbm_pkg::CMD_READ, 4, 9'h016, 1'b0);
        check("interval", 32'h00cf, 32'(refresh_interval));
        temp_level <= 8'hd0;
        idle(3);
        check("interval", 32'h002f, 32'(refresh_interval));
        // Five coverage and drive codes, self refresh in and out.
        for (int i = 0; i < 5; i++) begin
            set_ext({3'(i), 2'h0, prs[i]});
            check("coverage", 32'(prs[i]), 32'(partial_refresh_select));
            check("drive", 32'(i), 32'(output_drive_level));
            send(sbm_pkg::CMD_REF, 1'b0, 1'b1, 2'h0, 13'h0);
            idle(3);
            check("kept banks", 32'(msk[i]), 32'(refresh_bank_mask));
            send(sbm_pkg::CMD_NOP, 1'b0, 1'b0, 2'h0, 13'h0);
            idle(3);
            check("kept banks", 32'h0, 32'(refresh_bank_mask));
        end
        set_mode({1'b0, 2'h0, 3'h2, 1'b0, sbm_pkg::BL_2});
        check("coverage", 32'h6, 32'(partial_refresh_select));
        check("drive", 32'h4, 32'(output_drive_level));
        results();
    end
endmodule : test_sdram_burst_mode_config
